/* design/ics_current_status.sv */
// Purpose: current interrupt status register and core request outputs
// Assumes: request vector and levels are synchronous to mclk
// Notes:   one wait state on every avalon access
//
// Behaviour
// - bit 16 reads 0 while a request goes to the core and 1 when none does.
// - after reset bit 16 is 1, the level field 000 and the cause field 0x1f.
// - bits 10:8 hold the binary priority level of the request sent to the core.
// - with no request pending, level and cause carry no meaning for software.
// - bits 4:0 hold the five-bit code of the source sent to the core.
// - codes 8 to 15 are the serial ports, first dma group, self request and peripheral dma.
// - code 16 is pci 0, 17 to 19 timers, 20 is reserved and never shown, 21 is nand flash.
// - codes 22 to 31 are pci error, pci power, audio link, audio power, pci 1, second dma group and spi.
// - each cause code equals the index of its line in the source request vector.
//
// Our own choice: the Avalon-MM slave port.
module ics_current_status
  import ics_pkg::*;
#(
  parameter int NSRC = ics_pkg::NUM_SRC
) (
  input  wire logic                      mclk,
  input  wire logic                      rst_n,
  input  wire logic [NSRC-1:0]           source_request_vector,
  input  wire logic [NSRC*3-1:0]         source_level_vector,
  output logic                           core_irq_n,
  output logic [2:0]                     core_level,
  output logic [4:0]                     core_cause,
  output logic                           irq,
  input  wire logic [ics_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                      avs_read,
  input  wire logic                      avs_write,
  input  wire logic [ics_pkg::DATA_W-1:0] avs_writedata,
  input  wire logic [3:0]                avs_byteenable,
  output logic [ics_pkg::DATA_W-1:0]     avs_readdata,
  output logic                           avs_waitrequest
);
  import ics_pkg::*;

  // winner selection
  logic [NSRC-1:0]     req_ok;
  logic                enc_valid;
  logic [2:0]          enc_level;
  logic [4:0]          enc_cause;

  // the reserved line is never allowed to reach the core
  assign req_ok = source_request_vector & ~(NSRC'(1) << SRC_RESERVED);

  ics_prio_enc #(
    .N  (NSRC),
    .LW (LVL_W),
    .CW (CAUSE_W)
  ) u_enc (
    .req   (req_ok),
    .lvl   (source_level_vector),
    .valid (enc_valid),
    .level (enc_level),
    .cause (enc_cause)
  );

  // current request state
  logic                pend_q;
  logic                pend_d;
  logic [2:0]          lvl_q;
  logic [2:0]          lvl_d;
  logic [4:0]          cause_q;
  logic [4:0]          cause_d;

  assign pend_d  = enc_valid;
  // idle fields fall back to the reset pattern so reads stay predictable
  assign lvl_d   = enc_valid ? enc_level : LVL_RST;
  // code is the vector index itself, so the source map is fixed by wiring
  assign cause_d = enc_valid ? enc_cause : CAUSE_RST;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pend_q  <= ~IDLE_RST;
      lvl_q   <= LVL_RST;
      cause_q <= CAUSE_RST;
    end else begin
      pend_q  <= pend_d;
      lvl_q   <= lvl_d;
      cause_q <= cause_d;
    end
  end

  // core side outputs
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      core_irq_n <= IDLE_RST;
      core_level <= LVL_RST;
      core_cause <= CAUSE_RST;
    end else begin
      core_irq_n <= ~pend_d;
      core_level <= lvl_d;
      core_cause <= cause_d;
    end
  end

  // status word, reserved bits tied low
  logic [DATA_W-1:0]   cur_status;
  always_comb begin
    cur_status                        = '0;
    cur_status[IDLE_BIT]              = ~pend_q;
    cur_status[LVL_LSB +: LVL_W]      = lvl_q;
    cur_status[CAUSE_LSB +: CAUSE_W]  = cause_q;
  end

  // event detection
  logic [NUM_EVT-1:0]  evt_set;
  logic [NUM_EVT-1:0]  evt_clr;
  logic [NUM_EVT-1:0]  evt_sts_q;
  logic [NUM_EVT-1:0]  evt_en_q;
  logic [NUM_EVT-1:0]  evt_en_d;

  assign evt_set[EVT_RAISE]  = pend_d && !pend_q;
  assign evt_set[EVT_DROP]   = !pend_d && pend_q;
  assign evt_set[EVT_SWITCH] = pend_d && pend_q && (cause_d != cause_q);

  ics_evt_flags #(
    .N (NUM_EVT)
  ) u_flags (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .set     (evt_set),
    .clr     (evt_clr),
    .flags_q (evt_sts_q)
  );

  // avalon slave
  ics_bus_state_t      bus_q;
  ics_bus_state_t      bus_d;
  logic                req_any;
  logic                acc_done;
  logic                wr_done;
  logic                hit_cur;
  logic                hit_sts;
  logic                hit_clr;
  logic                hit_en;
  logic                be0;
  logic [DATA_W-1:0]   rd_mux;

  assign req_any  = avs_read || avs_write;
  assign acc_done = req_any && (bus_q == ICS_BUS_ACK);
  assign wr_done  = avs_write && (bus_q == ICS_BUS_ACK);
  assign hit_cur  = avs_address == OFS_CUR_STATUS;
  assign hit_sts  = avs_address == OFS_EVT_STATUS;
  assign hit_clr  = avs_address == OFS_EVT_CLEAR;
  assign hit_en   = avs_address == OFS_EVT_ENABLE;
  assign be0      = avs_byteenable[0];

  assign evt_clr  = (wr_done && hit_clr && be0) ? avs_writedata[NUM_EVT-1:0] : '0;
  assign evt_en_d = (wr_done && hit_en && be0) ? avs_writedata[NUM_EVT-1:0] : evt_en_q;

  // clear register reads zero, unmapped words read zero
  assign rd_mux = hit_cur ? cur_status :
                  hit_sts ? DATA_W'(evt_sts_q) :
                  hit_en  ? DATA_W'(evt_en_q) : '0;

  always_comb begin
    bus_d = bus_q;
    unique case (bus_q)
      ICS_BUS_IDLE: begin
        if (req_any) begin
          bus_d = ICS_BUS_ACK;
        end
      end
      ICS_BUS_ACK: begin
        bus_d = ICS_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bus_q           <= ICS_BUS_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= '0;
      evt_en_q        <= EVT_EN_RST;
    end else begin
      bus_q           <= bus_d;
      avs_waitrequest <= !(req_any && bus_q == ICS_BUS_IDLE);
      evt_en_q        <= evt_en_d;
      if (avs_read && bus_q == ICS_BUS_IDLE) begin
        avs_readdata <= rd_mux;
      end
    end
  end

  // level interrupt, registered so it leaves a flop
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |((evt_set | (evt_sts_q & ~evt_clr)) & evt_en_d);
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  logic                fresh_q;
  logic [NSRC-1:0]     req_prev_q;
  logic [NUM_EVT-1:0]  wr_low;

  assign wr_low = avs_writedata[NUM_EVT-1:0];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fresh_q    <= 1'b1;
      req_prev_q <= '0;
    end else begin
      fresh_q    <= 1'b0;
      req_prev_q <= req_ok;
    end
  end

  default clocking cb_main @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_bus_req;
    req_any && bus_q == ICS_BUS_IDLE;
  endsequence

  sequence s_bus_ack;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence

  sequence s_stat_write;
    avs_write && hit_cur && bus_q == ICS_BUS_ACK;
  endsequence

  sequence s_read_take;
    avs_read && bus_q == ICS_BUS_IDLE;
  endsequence

  sequence s_read_cur;
    s_read_take ##0 hit_cur;
  endsequence

  a_idle_bit_value: assert property (
    cur_status[IDLE_BIT] == !pend_q && core_irq_n == !pend_q)
    else $error("idle bit disagrees with request state");

  a_reset_values: assert property (
    fresh_q |-> cur_status == DATA_W'(32'h0001_001f))
    else $error("status word wrong after reset");

  a_level_follows: assert property (
    enc_valid |=> pend_q && lvl_q == $past(enc_level))
    else $error("level field does not follow winner");

  a_idle_fields: assert property (
    !pend_q |-> lvl_q == LVL_RST && cause_q == CAUSE_RST)
    else $error("idle fields not at reset pattern");

  a_cause_follows: assert property (
    enc_valid |=> cause_q == $past(enc_cause) && core_cause == cause_q)
    else $error("cause field does not follow winner");

  a_no_reserved: assert property (
    pend_q |-> cause_q != SRC_RESERVED)
    else $error("reserved source code reported");

  a_cause_index: assert property (
    pend_q |-> req_prev_q[cause_q])
    else $error("cause does not index an active line");

  a_write_ignored: assert property (
    s_stat_write |=> pend_q == $past(enc_valid) && cause_q == $past(cause_d))
    else $error("status write disturbed the fields");

  a_reserved_zero: assert property (
    s_read_cur |=> avs_readdata[31:17] == '0 && avs_readdata[15:11] == '0 &&
    avs_readdata[7:5] == '0)
    else $error("reserved status bits read nonzero");

  a_bus_answer: assert property (
    s_bus_req |-> s_bus_ack ##1 avs_waitrequest)
    else $error("slave did not answer after one wait state");

  a_event_raise: assert property (
    !pend_q ##1 pend_q |-> evt_sts_q[EVT_RAISE])
    else $error("raise event not recorded");

  a_read_capture: assert property (
    s_read_take |=> avs_readdata == $past(rd_mux))
    else $error("read data not taken at the accepting edge");

  a_wait_idle: assert property (
    !req_any && bus_q == ICS_BUS_IDLE |=> avs_waitrequest)
    else $error("waitrequest low with no request");

  a_ack_single: assert property (
    bus_q == ICS_BUS_ACK |=> bus_q == ICS_BUS_IDLE)
    else $error("acknowledge state held too long");

  a_core_idle: assert property (
    core_irq_n |-> core_level == LVL_RST && core_cause == CAUSE_RST)
    else $error("core fields not at idle pattern");

  a_core_match: assert property (
    !core_irq_n |-> core_level == lvl_q && core_cause == cause_q)
    else $error("core outputs disagree with status fields");

  a_core_reserved: assert property (
    !core_irq_n |-> core_cause != SRC_RESERVED)
    else $error("reserved source sent to core");

  a_code_ecc: assert property (
    req_ok == (NSRC'(1) << SRC_ECC_FAULT) |=> pend_q && cause_q == SRC_ECC_FAULT)
    else $error("ecc fault line gives wrong code");

  a_code_self: assert property (
    req_ok == (NSRC'(1) << SRC_SELF) |=> pend_q && cause_q == SRC_SELF)
    else $error("self request line gives wrong code");

  a_code_nand: assert property (
    req_ok == (NSRC'(1) << SRC_NAND) |=> pend_q && cause_q == SRC_NAND)
    else $error("nand flash line gives wrong code");

  a_code_spi: assert property (
    req_ok == (NSRC'(1) << SRC_SPI) |=> pend_q && cause_q == SRC_SPI)
    else $error("spi line gives wrong code");

  a_event_drop: assert property (
    pend_q ##1 !pend_q |-> evt_sts_q[EVT_DROP])
    else $error("drop event not recorded");

  a_event_switch: assert property (
    pend_q && enc_valid && enc_cause != cause_q |=> evt_sts_q[EVT_SWITCH])
    else $error("cause switch not recorded");

  a_set_wins: assert property (
    (|evt_set) |=> (evt_sts_q & $past(evt_set)) == $past(evt_set))
    else $error("event lost to a clear in the same cycle");

  a_clear_takes: assert property (
    (|evt_clr) |=> (evt_sts_q & $past(evt_clr) & ~$past(evt_set)) == '0)
    else $error("written clear did not drop the flag");

  a_irq_level: assert property (
    irq == |(evt_sts_q & evt_en_q))
    else $error("irq disagrees with enabled status");

  a_enable_write: assert property (
    wr_done && hit_en && be0 |=> evt_en_q == $past(wr_low))
    else $error("enable write not stored");

  a_enable_hold: assert property (
    !(wr_done && hit_en && be0) |=> $stable(evt_en_q))
    else $error("enable changed without a write");

endmodule : ics_current_status

/* design/ics_evt_flags.sv */
// Purpose: sticky event flags with write-one-to-clear
// Assumes: set and clear are one-cycle pulses
// Notes:   a set in the clearing cycle wins
module ics_evt_flags #(
  parameter int N = 3
) (
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic [N-1:0] set,
  input  wire logic [N-1:0] clr,
  output logic [N-1:0]      flags_q
);
  logic [N-1:0] flags_d;
  assign flags_d = set | (flags_q & ~clr);
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      flags_q <= '0;
    end else begin
      flags_q <= flags_d;
    end
  end
endmodule : ics_evt_flags

/* design/ics_pkg.sv */
// Purpose: constants of the current interrupt status block
// Assumes: 32-bit avalon data, byte addresses, 16 address bits
// Notes:   source codes equal request vector indices
package ics_pkg;
  localparam int          ADDR_W          = 16;
  localparam int          DATA_W          = 32;
  localparam int          NUM_SRC         = 32;
  localparam int          LVL_W           = 3;
  localparam int          CAUSE_W         = 5;
  localparam int          NUM_EVT         = 3;
  // register byte offsets
  localparam logic [15:0] OFS_CUR_STATUS  = 16'hf6a0;
  localparam logic [15:0] OFS_EVT_STATUS  = 16'hf6a4;
  localparam logic [15:0] OFS_EVT_CLEAR   = 16'hf6a8;
  localparam logic [15:0] OFS_EVT_ENABLE  = 16'hf6ac;
  // current status field layout
  localparam int          IDLE_BIT        = 16;
  localparam int          LVL_LSB         = 8;
  localparam int          CAUSE_LSB       = 0;
  // reset and idle values
  localparam logic        IDLE_RST        = 1'b1;
  localparam logic [2:0]  LVL_RST         = 3'h0;
  localparam logic [4:0]  CAUSE_RST       = 5'h1f;
  localparam logic [2:0]  EVT_EN_RST      = 3'h0;
  // source codes
  localparam logic [4:0]  SRC_ECC_FAULT   = 5'h00;
  localparam logic [4:0]  SRC_WR_TIMEOUT  = 5'h01;
  localparam logic [4:0]  SRC_EXT_BASE    = 5'h02;
  localparam logic [4:0]  SRC_SERIAL_BASE = 5'h08;
  localparam logic [4:0]  SRC_FIRST_DMA_GROUP_BASE   = 5'h0a;
  localparam logic [4:0]  SRC_SELF        = 5'h0e;
  localparam logic [4:0]  SRC_PDMA        = 5'h0f;
  localparam logic [4:0]  SRC_PCI0        = 5'h10;
  localparam logic [4:0]  SRC_TIMER_BASE  = 5'h11;
  localparam logic [4:0]  SRC_RESERVED    = 5'h14;
  localparam logic [4:0]  SRC_NAND        = 5'h15;
  localparam logic [4:0]  SRC_PCI_ERR     = 5'h16;
  localparam logic [4:0]  SRC_PCI_PWR     = 5'h17;
  localparam logic [4:0]  SRC_AUDIO       = 5'h18;
  localparam logic [4:0]  SRC_AUDIO_PWR   = 5'h19;
  localparam logic [4:0]  SRC_PCI1        = 5'h1a;
  localparam logic [4:0]  SRC_SECOND_DMA_GROUP_BASE   = 5'h1b;
  localparam logic [4:0]  SRC_SPI         = 5'h1f;
  // event bits
  localparam int          EVT_RAISE       = 0;
  localparam int          EVT_DROP        = 1;
  localparam int          EVT_SWITCH      = 2;
  typedef enum logic {ICS_BUS_IDLE, ICS_BUS_ACK} ics_bus_state_t;
endpackage : ics_pkg

/* design/ics_prio_enc.sv */
// Purpose: pick the winning request from the source vector
// Assumes: higher level wins, lower index wins a tie
// Notes:   purely combinational
module ics_prio_enc #(
  parameter int N     = 32,
  parameter int LW    = 3,
  parameter int CW    = 5
) (
  input  wire logic [N-1:0]    req,
  input  wire logic [N*LW-1:0] lvl,
  output logic                 valid,
  output logic [LW-1:0]        level,
  output logic [CW-1:0]        cause
);
  always_comb begin
    valid = 1'b0;
    level = '0;
    cause = '0;
    for (int i = 0; i < N; i++) begin
      if (req[i] && (!valid || lvl[i*LW +: LW] > level)) begin
        valid = 1'b1;
        level = lvl[i*LW +: LW];
        cause = CW'(i);
      end
    end
  end
endmodule : ics_prio_enc

/* dv/ics_current_status_tb.sv */
// Purpose: self-checking bench of the current status block
// Assumes: one wait state per access, core outputs one edge late
// Notes:   the design's own assertions run alongside
module ics_current_status_tb;
  import ics_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic [31:0] req;
  logic [95:0] lvl;
  logic        core_irq_n;
  logic [2:0]  core_level;
  logic [4:0]  core_cause;
  logic        irq;
  logic [15:0] avs_address = '0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [3:0]  avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  int          miscompares = 0;
  int          compares = 0;
  int          cycles = 0;
  logic [31:0] rd;
  logic [95:0] lv;
  always #4 mclk = ~mclk;
  ics_src_model u_ics_src_model (.mclk(mclk), .req(req), .lvl(lvl));
  ics_current_status u_ics_current_status (
    .mclk(mclk), .rst_n(rst_n), .source_request_vector(req),
    .source_level_vector(lvl), .core_irq_n(core_irq_n),
    .core_level(core_level), .core_cause(core_cause), .irq(irq),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  task summarize;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize
  // the ceiling sits far above the few hundred cycles the tests need
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      summarize;
    end
  end
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task bus_rd(input logic [15:0] a, output logic [31:0] d);
    @(posedge mclk);
    avs_read <= 1'b1;
    avs_address <= a;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask : bus_rd
  task bus_wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge mclk);
    avs_write <= 1'b1;
    avs_address <= a;
    avs_writedata <= d;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask : bus_wr
  // idle word: bit 16 set, level 000, cause 1f
  function automatic logic [31:0] word(input int i, input logic [2:0] l);
    if (i == 20) return 32'h0001001f;
    return {21'h0, l, 3'h0, i[4:0]};
  endfunction : word
  initial begin
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    chk("reset irq_n", 32'h1, {31'h0, core_irq_n});
    chk("reset cause", 32'h1f, {27'h0, core_cause});
    bus_rd(16'hf6a0, rd);
    chk("reset status", 32'h0001001f, rd);
    for (int i = 0; i < 32; i++) begin
      lv = '0;
      lv[3*i +: 3] = i[2:0];
      u_ics_src_model.put(32'h1 << i, lv);
      bus_rd(16'hf6a0, rd);
      chk("one source", word(i, i[2:0]), rd);
    end
    lv = '0;
    lv[3*3 +: 3] = 3'h2;
    lv[3*9 +: 3] = 3'h6;
    lv[3*25 +: 3] = 3'h6;
    u_ics_src_model.put(32'h02000208, lv);
    bus_wr(16'hf6a0, 32'hffffffff);
    bus_rd(16'hf6a0, rd);
    chk("winner kept", 32'h00000609, rd);
    chk("core level", 32'h6, {29'h0, core_level});
    chk("core cause", 32'h9, {27'h0, core_cause});
    chk("core irq_n", 32'h0, {31'h0, core_irq_n});
    bus_rd(16'hf6a4, rd);
    chk("events all", 32'h7, rd);
    u_ics_src_model.put(32'h0, '0);
    bus_wr(16'hf6a8, 32'h7);
    bus_wr(16'hf6ac, 32'h1);
    bus_rd(16'hf6ac, rd);
    chk("enable", 32'h1, rd);
    chk("irq idle", 32'h0, {31'h0, irq});
    lv = '0;
    lv[3*31 +: 3] = 3'h7;
    u_ics_src_model.put(32'h80000000, lv);
    repeat (3) @(posedge mclk);
    chk("irq raised", 32'h1, {31'h0, irq});
    bus_rd(16'hf6a4, rd);
    chk("event raise", 32'h1, rd);
    bus_rd(16'hf6a0, rd);
    chk("spi status", 32'h0000071f, rd);
    bus_wr(16'hf6a8, 32'h1);
    repeat (2) @(posedge mclk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    bus_wr(16'hf6ac, 32'h0);
    avs_byteenable <= 4'h0;
    bus_wr(16'hf6ac, 32'h7);
    avs_byteenable <= 4'hf;
    bus_rd(16'hf6ac, rd);
    chk("lane0 off", 32'h0, rd);
    u_ics_src_model.put(32'h0, '0);
    repeat (3) @(posedge mclk);
    chk("irq masked", 32'h0, {31'h0, irq});
    bus_rd(16'hf6a4, rd);
    chk("event drop", 32'h2, rd);
    bus_rd(16'hf6a0, rd);
    chk("idle status", 32'h0001001f, rd);
    bus_rd(16'hf6a8, rd);
    chk("clear reads", 32'h0, rd);
    bus_rd(16'hf6b0, rd);
    chk("unmapped", 32'h0, rd);
    // reset in mid-run while a source is still requesting
    u_ics_src_model.put(32'h20, '0);
    @(posedge mclk);
    rst_n <= 1'b0;
    @(posedge mclk);
    chk("mid reset irq_n", 32'h1, {31'h0, core_irq_n});
    chk("mid reset level", 32'h0, {29'h0, core_level});
    chk("mid reset cause", 32'h1f, {27'h0, core_cause});
    rst_n <= 1'b1;
    bus_rd(16'hf6a0, rd);
    chk("after reset", 32'h00000005, rd);
    bus_rd(16'hf6a4, rd);
    chk("flags after reset", 32'h1, rd);
    summarize;
  end
endmodule : ics_current_status_tb

/* dv/ics_src_model.sv */
// Purpose: far-side source lines feeding the status block
// Assumes: lines change right after a rising edge
// Notes:   levels sit at [3i+2:3i]
module ics_src_model (
  input  wire logic        mclk,
  output logic [31:0]      req,
  output logic [95:0]      lvl
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    req = '0;
    lvl = '0;
  end
  task put(input logic [31:0] r, input logic [95:0] l);
    @(posedge mclk);
    req <= r;
    lvl <= l;
  endtask : put
endmodule : ics_src_model
